// ==== logic/mtt_telemetry.sv ====
// telemetry registers, serial slave port, tach output
// assumes status on core_clk; serial
// pins oversampled by free-running linkClk
// Operation
// - 4-bit select divides tach; zero: one per cycle
// - tach selects cover 2 to 32 poles
// - two pulses per revolution for 4/6/8 poles
// - tach follows commanded drive steps
// - locked motor holds tach high
// - open-loop policy: follow, high, first-start only
// - current, command, duty and sense words refresh continuously
// - fault word holds heat, current, stall, supply flags
// - writing 0xFF to faults clears them
// - speed word is tenths of hertz
// - period word counts 10 us units
// - bemf integral stored each electrical cycle
// - sector code is base plus advance, wrapped
// - supply sampled periodically while spinning as 8-bit code
// - input command readable, 255 full scale
// - applied duty readable separately
// - slave answers at address 101 0010
// - control, status and config register groups
`include "mtt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mtt_telemetry #(
  parameter int          SUPPLY_SAMPLE_CYC = `MTT_SUPPLY_SAMPLE_US * 1000 / `MTT_CORE_CLK_NS,
  parameter int          BEMF_SHIFT        = 4,
  parameter logic [7:0]  PART_CODE         = 8'h5A, // arbitrary value
  parameter logic [7:0]  REV_CODE          = 8'h01  // arbitrary value
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic                linkClk,
  input  wire logic                linkRst,
  input  wire logic                sclIn,
  input  wire logic                sdaIn,
  output logic                     sdaOut,
  output logic                     sdaOeN,
  input  wire mtt_pkg::mtt_status_s status,
  output logic                     tachOut,
  output logic                     hostCmdSelect,
  output logic [8:0]               hostSpeedValue
);
  localparam int UNIT_CYC = `MTT_PERIOD_UNIT_CYC;
  localparam logic [6:0][15:0] CFG_RST = {`MTT_CFG6_RST, `MTT_CFG5_RST, `MTT_CFG4_RST,
    `MTT_CFG3_RST, `MTT_CFG2_RST, `MTT_CFG1_RST, `MTT_CFG0_RST};

  if (SUPPLY_SAMPLE_CYC < 2 || SUPPLY_SAMPLE_CYC > 65535) begin : badSample
    $error("supply sample interval out of range");
  end
  if (BEMF_SHIFT < 0 || BEMF_SHIFT > 12) begin : badShift
    $error("bemf shift out of range");
  end

  mtt_pkg::mtt_core_s coreQ;
  mtt_pkg::mtt_core_s coreN;
  mtt_pkg::mtt_link_s linkQ;
  mtt_pkg::mtt_link_s linkN;

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic inGroup(input logic [7:0] addr, input logic [7:0] base);
    inGroup = (addr >= base) && (addr < base + `MTT_REG_GROUP_LEN);
  endfunction

  function automatic logic [7:0] sectorBase(input logic [2:0] idx);
    case (idx)
      3'h0:    sectorBase = 8'h00;
      3'h1:    sectorBase = 8'h2B;
      3'h2:    sectorBase = 8'h55;
      3'h3:    sectorBase = 8'h80;
      3'h4:    sectorBase = 8'hAB;
      3'h5:    sectorBase = 8'hD5;
      default: sectorBase = 8'h00;
    endcase
  endfunction

  // advance 30/60/90/120 degrees, 256 per cycle
  function automatic logic [7:0] advanceCode(input logic [1:0] sel);
    case (sel)
      2'h0:    advanceCode = 8'h16;
      2'h1:    advanceCode = 8'h2C;
      2'h2:    advanceCode = 8'h3F;
      default: advanceCode = 8'h55;
    endcase
  endfunction

  // 30-degree steps; select 0 toggles per half cycle
  // (4 poles), +2 poles a step to 32, 15 means 2 poles
  function automatic logic [5:0] tachSteps(input logic [3:0] sel);
    if (sel == 4'hF) begin
      tachSteps = 6'h03;
    end else begin
      tachSteps = 6'h06 + 6'(3 * sel);
    end
  endfunction

  function automatic logic [15:0] readWord(input logic [7:0] addr,
                                           input mtt_pkg::mtt_core_s c);
    logic [7:0] off;
    off = 8'h00;
    readWord = 16'h0000;
    if (inGroup(addr, `MTT_REG_CTL_BASE)) begin
      off = addr - `MTT_REG_CTL_BASE;
      readWord = c.ctl[off[2:0]];
    end else if (inGroup(addr, `MTT_REG_CFG_BASE)) begin
      off = addr - `MTT_REG_CFG_BASE;
      readWord = c.cfg[off[2:0]];
    end else begin
      case (addr)
        `MTT_REG_FAULT:   readWord = c.fault;
        `MTT_REG_SPEED:   readWord = c.speed;
        `MTT_REG_PERIOD:  readWord = c.period;
        `MTT_REG_BEMF:    readWord = c.bemf;
        `MTT_REG_CURRENT: readWord = {5'h00, c.current};
        `MTT_REG_SECTOR:  readWord = {c.sector, c.supply};
        `MTT_REG_COMMAND: readWord = {c.command, c.duty};
        `MTT_REG_SENSE:   readWord = {6'h00, c.sense};
        `MTT_REG_IDENT:   readWord = {PART_CODE, REV_CODE};
        default:          readWord = 16'h0000;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // core domain: register bank, measurements, tach

  always_comb begin
    logic [16:0] rem;
    logic [19:0] quo;
    logic [27:0] bemfScaled;
    logic [7:0]  off;
    logic        holdHigh;
    logic [1:0]  policy;
    rem = 17'h00000;
    quo = 20'h00000;
    bemfScaled = 28'h0000000;
    off = 8'h00;
    holdHigh = 1'b0;
    policy = 2'h0;
    coreN = coreQ;
    if (clkEn) begin
      coreN.reqMeta = linkQ.reqTgl;
      coreN.reqSync = coreQ.reqMeta;
      // clear first: a same-cycle fault wins
      if (coreQ.reqSync != coreQ.reqSeen) begin
        coreN.reqSeen = coreQ.reqSync;
        coreN.ackTgl = coreQ.reqSync;
        if (linkQ.reqWrite) begin
          if (linkQ.reqAddr == `MTT_REG_FAULT && linkQ.reqData[7:0] == `MTT_FAULT_CLEAR) begin
            coreN.fault = 16'h0000;
          end else if (inGroup(linkQ.reqAddr, `MTT_REG_CTL_BASE)) begin
            off = linkQ.reqAddr - `MTT_REG_CTL_BASE;
            coreN.ctl[off[2:0]] = linkQ.reqData;
          end else if (inGroup(linkQ.reqAddr, `MTT_REG_CFG_BASE)) begin
            off = linkQ.reqAddr - `MTT_REG_CFG_BASE;
            coreN.cfg[off[2:0]] = linkQ.reqData;
          end
        end else begin
          coreN.rdWord = readWord(linkQ.reqAddr, coreQ);
        end
      end
      coreN.fault = coreN.fault | (status.faultSet & `MTT_FAULT_MASK);

      coreN.current = status.phaseCurrent;
      coreN.command = status.inputCommand;
      coreN.duty = status.appliedDuty;
      coreN.sense = status.senseLevel;
      if (status.sectorValid) begin
        coreN.sector = sectorBase(status.sectorIdx)
                     + advanceCode(coreQ.cfg[6][`MTT_ADVANCE_LSB +: 2]);
      end

      if (status.spinning) begin
        if (coreQ.supTimer >= 16'(SUPPLY_SAMPLE_CYC - 1)) begin
          coreN.supTimer = 16'h0000;
          coreN.supply = status.supplyAdc;
        end else begin
          coreN.supTimer = coreQ.supTimer + 16'h0001;
        end
      end else begin
        coreN.supTimer = 16'h0000;
      end

      // 10 us units between crossings, saturating
      if (status.spinning) begin
        if (coreQ.unitCnt == 9'(UNIT_CYC - 1)) begin
          coreN.unitCnt = 9'h000;
          if (coreQ.perAcc != 16'hFFFF) begin
            coreN.perAcc = coreQ.perAcc + 16'h0001;
          end
        end else begin
          coreN.unitCnt = coreQ.unitCnt + 9'h001;
        end
        if (status.zeroCrossU) begin
          coreN.unitCnt = 9'h000;
          coreN.perAcc = 16'h0000;
          if (coreQ.perAcc != 16'h0000) begin
            coreN.period = coreQ.perAcc;
            coreN.divBusy = 1'b1;
            coreN.divStep = 5'h00;
            coreN.divRem = 17'h00000;
            coreN.divQ = `MTT_SPEED_NUMERATOR;
          end
        end
      end else begin
        coreN.unitCnt = 9'h000;
        coreN.perAcc = 16'h0000;
      end

      // speed = 1e6 / period, a bit per cycle
      // a new crossing restarts the 20-cycle division
      if (coreQ.divBusy && !(status.spinning && status.zeroCrossU)) begin
        rem = {coreQ.divRem[15:0], coreQ.divQ[19]};
        quo = {coreQ.divQ[18:0], 1'b0};
        if (rem >= {1'b0, coreQ.period}) begin
          rem = rem - {1'b0, coreQ.period};
          quo[0] = 1'b1;
        end
        coreN.divRem = rem;
        coreN.divQ = quo;
        coreN.divStep = coreQ.divStep + 5'h01;
        if (coreQ.divStep == 5'h13) begin
          coreN.divBusy = 1'b0;
          coreN.speed = (|quo[19:16]) ? 16'hFFFF : quo[15:0];
        end
      end

      // integrate over the window, store at its end
      coreN.winPrev = status.bemfWindow;
      if (status.bemfWindow) begin
        coreN.bemfAcc = coreQ.bemfAcc + 28'(status.bemfSample);
      end else if (coreQ.winPrev) begin
        bemfScaled = coreQ.bemfAcc >> BEMF_SHIFT;
        coreN.bemf = (|bemfScaled[27:16]) ? 16'hFFFF : bemfScaled[15:0];
        coreN.bemfAcc = 28'h0000000;
      end

      if (status.driveStep) begin
        if (coreQ.tachCnt >= tachSteps(coreQ.cfg[0][`MTT_TACH_DIV_LSB +: 4]) - 6'h01) begin
          coreN.tachCnt = 6'h00;
          coreN.tachDiv = ~coreQ.tachDiv;
        end else begin
          coreN.tachCnt = coreQ.tachCnt + 6'h01;
        end
      end
      coreN.olPrev = status.openLoop;
      if (coreQ.olPrev && !status.openLoop) begin
        coreN.firstDone = 1'b1;
      end
      policy = coreQ.cfg[0][`MTT_TACH_POL_LSB +: 2];
      holdHigh = status.locked
               || (status.openLoop && (policy == 2'h1
                   || (policy == 2'h2 && coreQ.firstDone)));
      coreN.tachOut = holdHigh ? 1'b1 : coreQ.tachDiv;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      coreQ <= '0;
      coreQ.cfg <= CFG_RST;
    end else begin
      coreQ <= coreN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: oversampled serial slave

  always_comb begin
    logic rise;
    logic fall;
    logic startCond;
    logic stopCond;
    logic idle;
    logic [15:0] word;
    rise = 1'b0;
    fall = 1'b0;
    startCond = 1'b0;
    stopCond = 1'b0;
    idle = 1'b0;
    word = 16'h0000;
    linkN = linkQ;
    linkN.sclMeta = sclIn;
    linkN.sclSync = linkQ.sclMeta;
    linkN.sclPrev = linkQ.sclSync;
    linkN.sdaMeta = sdaIn;
    linkN.sdaSync = linkQ.sdaMeta;
    linkN.sdaPrev = linkQ.sdaSync;
    linkN.ackMeta = coreQ.ackTgl;
    linkN.ackSync = linkQ.ackMeta;
    rise = linkQ.sclSync && !linkQ.sclPrev;
    fall = !linkQ.sclSync && linkQ.sclPrev;
    startCond = linkQ.sclSync && linkQ.sclPrev && linkQ.sdaPrev && !linkQ.sdaSync;
    stopCond = linkQ.sclSync && linkQ.sclPrev && !linkQ.sdaPrev && linkQ.sdaSync;
    idle = (linkQ.reqTgl == linkQ.ackSync);
    word = coreQ.rdWord;
    if (startCond) begin
      linkN.state = mtt_pkg::LK_ADDR;
      linkN.bitCnt = 4'h0;
      linkN.sdaOeN = 1'b1;
    end else if (stopCond) begin
      linkN.state = mtt_pkg::LK_IDLE;
      linkN.sdaOeN = 1'b1;
    end else begin
      case (linkQ.state)
        mtt_pkg::LK_ADDR, mtt_pkg::LK_PTR, mtt_pkg::LK_WR: begin
          if (rise) begin
            linkN.sh = {linkQ.sh[6:0], linkQ.sdaSync};
            linkN.bitCnt = linkQ.bitCnt + 4'h1;
          end else if (fall && linkQ.bitCnt == 4'h8) begin
            linkN.bitCnt = 4'h0;
            linkN.sdaOeN = 1'b0;
            if (linkQ.state == mtt_pkg::LK_ADDR) begin
              if (linkQ.sh[7:1] == `MTT_I2C_ADDR) begin
                linkN.rw = linkQ.sh[0];
                linkN.state = mtt_pkg::LK_ADDR_ACK;
              end else begin
                linkN.sdaOeN = 1'b1;
                linkN.state = mtt_pkg::LK_IDLE;
              end
            end else if (linkQ.state == mtt_pkg::LK_PTR) begin
              // fetch now, ready before a repeated start
              linkN.ptr = linkQ.sh;
              linkN.byteLo = 1'b0;
              linkN.state = mtt_pkg::LK_PTR_ACK;
              if (idle) begin
                linkN.reqWrite = 1'b0;
                linkN.reqAddr = linkQ.sh;
                linkN.reqTgl = ~linkQ.reqTgl;
              end
            end else begin
              linkN.state = mtt_pkg::LK_WR_ACK;
              linkN.byteLo = ~linkQ.byteLo;
              if (!linkQ.byteLo) begin
                linkN.wrHi = linkQ.sh;
              end else if (idle) begin
                linkN.reqWrite = 1'b1;
                linkN.reqAddr = linkQ.ptr;
                linkN.reqData = {linkQ.wrHi, linkQ.sh};
                linkN.reqTgl = ~linkQ.reqTgl;
              end
            end
          end
        end
        mtt_pkg::LK_ADDR_ACK: begin
          if (fall) begin
            if (linkQ.rw) begin
              linkN.byteLo = 1'b0;
              linkN.sh = word[15:8];
              linkN.sdaOeN = word[15];
              linkN.state = mtt_pkg::LK_RD;
            end else begin
              linkN.sdaOeN = 1'b1;
              linkN.state = mtt_pkg::LK_PTR;
            end
          end
        end
        mtt_pkg::LK_PTR_ACK, mtt_pkg::LK_WR_ACK: begin
          if (fall) begin
            linkN.sdaOeN = 1'b1;
            linkN.state = mtt_pkg::LK_WR;
          end
        end
        mtt_pkg::LK_RD: begin
          if (rise) begin
            linkN.bitCnt = linkQ.bitCnt + 4'h1;
          end else if (fall) begin
            if (linkQ.bitCnt == 4'h8) begin
              linkN.bitCnt = 4'h0;
              linkN.sdaOeN = 1'b1;
              linkN.state = mtt_pkg::LK_RD_ACK;
            end else begin
              linkN.sh = {linkQ.sh[6:0], 1'b0};
              linkN.sdaOeN = linkQ.sh[6];
            end
          end
        end
        mtt_pkg::LK_RD_ACK: begin
          if (rise) begin
            linkN.mAck = !linkQ.sdaSync;
          end else if (fall) begin
            if (linkQ.mAck) begin
              linkN.byteLo = ~linkQ.byteLo;
              linkN.sh = linkQ.byteLo ? word[15:8] : word[7:0];
              linkN.sdaOeN = linkQ.byteLo ? word[15] : word[7];
              linkN.state = mtt_pkg::LK_RD;
            end else begin
              linkN.state = mtt_pkg::LK_IDLE;
            end
          end
        end
        default: begin
          linkN.state = mtt_pkg::LK_IDLE;
          linkN.sdaOeN = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkQ <= '0;
      linkQ.sdaOeN <= 1'b1;
      linkQ.sclMeta <= 1'b1;
      linkQ.sclSync <= 1'b1;
      linkQ.sclPrev <= 1'b1;
      linkQ.sdaMeta <= 1'b1;
      linkQ.sdaSync <= 1'b1;
      linkQ.sdaPrev <= 1'b1;
    end else begin
      linkQ <= linkN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops

  assign sdaOut = linkQ.sdaOut;
  assign sdaOeN = linkQ.sdaOeN;
  assign tachOut = coreQ.tachOut;
  assign hostCmdSelect = coreQ.ctl[0][`MTT_HOST_COMMAND_SELECT_BIT];
  assign hostSpeedValue = coreQ.ctl[0][8:0];
endmodule
`default_nettype wire

// ==== shared/mtt_cfg.svh ====
// telemetry bank constants
// included by bare name
`ifndef MTT_CFG_SVH
`define MTT_CFG_SVH
`define MTT_I2C_ADDR        7'h52
`define MTT_REG_FAULT       8'h00
`define MTT_REG_SPEED       8'h01
`define MTT_REG_PERIOD      8'h02
`define MTT_REG_BEMF        8'h03
`define MTT_REG_CURRENT     8'h04
`define MTT_REG_SECTOR      8'h05
`define MTT_REG_COMMAND     8'h06
`define MTT_REG_SENSE       8'h07
`define MTT_REG_IDENT       8'h08
`define MTT_REG_CTL_BASE    8'h30
`define MTT_REG_CFG_BASE    8'h90
`define MTT_REG_GROUP_LEN   8'h07
`define MTT_FAULT_CLEAR     8'hFF
`define MTT_FAULT_MASK      16'hFFBF
`define MTT_HOST_COMMAND_SELECT_BIT    15
`define MTT_TACH_DIV_LSB    8
`define MTT_TACH_POL_LSB    12
`define MTT_ADVANCE_LSB     14
`define MTT_CFG0_RST        16'hC000
`define MTT_CFG1_RST        16'h0049
`define MTT_CFG2_RST        16'h00C1
`define MTT_CFG3_RST        16'h3788
`define MTT_CFG4_RST        16'h3BAF
`define MTT_CFG5_RST        16'h7840
`define MTT_CFG6_RST        16'h007A
`define MTT_CORE_CLK_NS     40
`define MTT_PERIOD_UNIT_NS  10000
`define MTT_PERIOD_UNIT_CYC ((`MTT_PERIOD_UNIT_NS + `MTT_CORE_CLK_NS - 1) / `MTT_CORE_CLK_NS)
`define MTT_SUPPLY_SAMPLE_US 1000
`define MTT_SPEED_NUMERATOR 20'hF4240
`endif

// ==== shared/mtt_pkg.sv ====
// telemetry bank types
// needs no other file
package mtt_pkg;
  typedef enum logic [3:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_PTR, LK_PTR_ACK,
    LK_WR, LK_WR_ACK, LK_RD, LK_RD_ACK
  } mtt_link_e;

  typedef struct packed {
    logic [15:0] faultSet;
    logic        spinning;
    logic        zeroCrossU;
    logic [11:0] bemfSample;
    logic        bemfWindow;
    logic [10:0] phaseCurrent;
    logic        sectorValid;
    logic [2:0]  sectorIdx;
    logic [7:0]  supplyAdc;
    logic [7:0]  inputCommand;
    logic [7:0]  appliedDuty;
    logic [9:0]  senseLevel;
    logic        driveStep;
    logic        openLoop;
    logic        locked;
  } mtt_status_s;

  typedef struct packed {
    logic [15:0]      fault;
    logic [15:0]      speed;
    logic [15:0]      period;
    logic [15:0]      bemf;
    logic [10:0]      current;
    logic [7:0]       sector;
    logic [7:0]       supply;
    logic [7:0]       command;
    logic [7:0]       duty;
    logic [9:0]       sense;
    logic [6:0][15:0] ctl;
    logic [6:0][15:0] cfg;
    logic [15:0]      rdWord;
    logic             reqMeta;
    logic             reqSync;
    logic             reqSeen;
    logic             ackTgl;
    logic [8:0]       unitCnt;
    logic [15:0]      perAcc;
    logic             divBusy;
    logic [4:0]       divStep;
    logic [16:0]      divRem;
    logic [19:0]      divQ;
    logic [27:0]      bemfAcc;
    logic             winPrev;
    logic [15:0]      supTimer;
    logic [5:0]       tachCnt;
    logic             tachDiv;
    logic             tachOut;
    logic             olPrev;
    logic             firstDone;
  } mtt_core_s;

  typedef struct packed {
    logic        sclMeta;
    logic        sclSync;
    logic        sclPrev;
    logic        sdaMeta;
    logic        sdaSync;
    logic        sdaPrev;
    logic        ackMeta;
    logic        ackSync;
    mtt_link_e   state;
    logic [7:0]  sh;
    logic [3:0]  bitCnt;
    logic        byteLo;
    logic        rw;
    logic        mAck;
    logic [7:0]  ptr;
    logic [7:0]  wrHi;
    logic        reqTgl;
    logic        reqWrite;
    logic [7:0]  reqAddr;
    logic [15:0] reqData;
    logic        sdaOeN;
    logic        sdaOut;
  } mtt_link_s;
endpackage

// ==== verif/mtt_i2c_host.sv ====
// serial host model: word writes and reads
// assumes sdaLine is the resolved wire with its pull-up
`timescale 1ns/1ps
`default_nettype none
module mtt_i2c_host (
  input  wire logic  linkClk,
  input  wire logic  sdaLine,
  output logic       scl,
  output logic       sda,
  output logic       rdStrobe,
  output logic [15:0] rdWord,
  output logic [7:0] nacks
);
  // slow enough for the core handshake
  localparam int H = 32;
  localparam logic [6:0] DEV = 7'h52;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    rdStrobe = 1'b0;
    rdWord = 16'h0000;
    nacks = 8'h00;
  end
  task automatic set(input logic c, input logic d, input int n);
    scl <= c;
    sda <= d;
    repeat (n) @(posedge linkClk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic bit_io(input logic b, output logic r);
    set(1'b0, sda, 4);
    set(1'b0, b, H);
    set(1'b1, b, H);
    r = sdaLine;
  endtask
  // a = 1: start, a = 0: stop
  task automatic cond(input logic a);
    set(1'b0, sda, 4);
    set(1'b0, a, H);
    set(1'b1, a, H);
    set(1'b1, ~a, H);
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) nacks <= nacks + 8'h01;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic write_word(input logic [6:0] dv, input logic [7:0] a, input logic [15:0] d);
    cond(1'b1);
    put_byte({dv, 1'b0});
    put_byte(a);
    put_byte(d[15:8]);
    put_byte(d[7:0]);
    cond(1'b0);
  endtask
  task automatic read_word(input logic [7:0] a);
    logic [7:0] hi;
    logic [7:0] lo;
    cond(1'b1);
    put_byte({DEV, 1'b0});
    put_byte(a);
    cond(1'b1);
    put_byte({DEV, 1'b1});
    get_byte(1'b0, hi);
    get_byte(1'b1, lo);
    cond(1'b0);
    rdWord <= {hi, lo};
    rdStrobe <= 1'b1;
    @(posedge linkClk);
    rdStrobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/mtt_telemetry_monitor.sv ====
// port checker for the telemetry bank
// assumes binding into the bank
`timescale 1ns/1ps
`default_nettype none
module mtt_telemetry_monitor (
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 clkEn,
  input wire logic                 linkClk,
  input wire logic                 linkRst,
  input wire logic                 sclIn,
  input wire logic                 sdaIn,
  input wire logic                 sdaOut,
  input wire logic                 sdaOeN,
  input wire mtt_pkg::mtt_status_s status,
  input wire logic                 tachOut,
  input wire logic                 hostCmdSelect,
  input wire logic [8:0]           hostSpeedValue
);
  sequence s_ack_on;
    $fell(sdaOeN);
  endsequence
  sequence s_ack_off;
    $rose(sdaOeN);
  endsequence
  ////////////////////////////////////////////////////////////////
  a_link_idle_reset: assert property (@(posedge linkClk) $fell(linkRst) |-> sdaOeN)
    else $error("line driven after reset");
  a_drive_only_low: assert property (@(posedge linkClk) disable iff (linkRst) !sdaOeN |-> !sdaOut)
    else $error("drove high");
  a_oe_scl_low: assert property (@(posedge linkClk) disable iff (linkRst) $changed(sdaOeN) |-> !sclIn)
    else $error("drive changed, clock high");
  a_ack_stands: assert property (@(posedge linkClk) disable iff (linkRst) s_ack_on |=> !sdaOeN [*8])
    else $error("driven bit too short");
  a_ack_released: assert property (@(posedge linkClk) disable iff (linkRst) s_ack_on |-> ##[1:1000] s_ack_off)
    else $error("line never released");
  ////////////////////////////////////////////////////////////////
  a_core_reset_outs: assert property (@(posedge core_clk) $fell(rst) |-> !tachOut && !hostCmdSelect && hostSpeedValue == 9'h000)
    else $error("outputs not reset");
  a_lock_tach_high: assert property (@(posedge core_clk) disable iff (rst) clkEn && status.locked |=> tachOut)
    else $error("tach low while locked");
  a_tach_needs_step: assert property (@(posedge core_clk) disable iff (rst)
    !status.driveStep && !$past(status.driveStep) && !status.locked && !$past(status.locked)
    && !status.openLoop && !$past(status.openLoop) |=> $stable(tachOut))
    else $error("tach moved without step");
endmodule
bind mtt_telemetry mtt_telemetry_monitor i_mon (
  .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .linkClk(linkClk), .linkRst(linkRst),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .status(status),
  .tachOut(tachOut), .hostCmdSelect(hostCmdSelect), .hostSpeedValue(hostSpeedValue)
);
`default_nettype wire

// ==== verif/mtt_telemetry_tb.sv ====
// bench: host model on the link, status on core_clk
// assumes the checker is bound by its own file
`timescale 1ns/1ps
`default_nettype none
module mtt_telemetry_tb;
  logic                 core_clk, linkClk, rst, linkRst;
  logic                 scl, hostSda, sdaLine, sdaOut, sdaOeN, rdStrobe;
  logic                 tachOut, hostCmdSelect, tachPrev;
  logic [8:0]           hostSpeedValue;
  logic [15:0]          rdWord;
  logic [7:0]           nacks, cmd, duty, sup;
  logic [15:0]          expQ[$];
  mtt_pkg::mtt_status_s st;
  int                   miscompares, checksDone, tachChg, n0;
  int                   sels[3] = '{0, 2, 15};
  int                   togs[3] = '{2, 1, 4};
  always #20 core_clk = ~core_clk;
  always #7.5 linkClk = ~linkClk;
  assign sdaLine = hostSda & sdaOeN;
  mtt_telemetry #(.SUPPLY_SAMPLE_CYC(8), .PART_CODE(8'h3C), .REV_CODE(8'h07)) i_dut (
    .core_clk(core_clk), .rst(rst), .clkEn(1'b1), .linkClk(linkClk), .linkRst(linkRst),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .status(st),
    .tachOut(tachOut), .hostCmdSelect(hostCmdSelect), .hostSpeedValue(hostSpeedValue));
  mtt_i2c_host i_host (.linkClk(linkClk), .sdaLine(sdaLine), .scl(scl), .sda(hostSda),
    .rdStrobe(rdStrobe), .rdWord(rdWord), .nacks(nacks));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    i_host.read_word(a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host.write_word(7'h52, a, d);
  endtask
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge core_clk) st.driveStep <= 1'b1;
      @(posedge core_clk) st.driveStep <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic tach_count(input string what, input int n, input int e);
    n0 = tachChg;
    steps(n);
    check(what, 16'(tachChg - n0), 16'(e));
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge linkClk) if (rdStrobe === 1'b1) check("read word", rdWord, expQ.pop_front());
  always @(posedge core_clk) begin
    tachPrev <= tachOut;
    if (!rst && tachOut !== tachPrev) tachChg <= tachChg + 1;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    core_clk = 1'b0;
    linkClk = 1'b0;
    rst = 1'b1;
    linkRst = 1'b1;
    st = '0;
    void'($urandom(88324));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    linkRst <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(8'h90, 16'hC000);
    rd(8'h96, 16'h007A);
    rd(8'h08, 16'h3C07);
    rd(8'h10, 16'h0000);
    wr(8'h30, 16'h8123);
    check("host_command_select", {15'h0, hostCmdSelect}, 16'h0001);
    check("speed value", {7'h00, hostSpeedValue}, 16'h0123);
    rd(8'h30, 16'h8123);
    i_host.write_word(7'h53, 8'h31, 16'hBEEF);
    rd(8'h31, 16'h0000);
    wr(8'h96, 16'hC07A);
    cmd = 8'($urandom);
    duty = 8'($urandom);
    sup = 8'($urandom);
    @(posedge core_clk);
    {st.inputCommand, st.appliedDuty, st.supplyAdc} <= {cmd, duty, sup};
    {st.phaseCurrent, st.senseLevel, st.bemfSample} <= {11'h5A3, 10'h2C7, 12'h010};
    {st.sectorIdx, st.sectorValid, st.spinning, st.bemfWindow} <= {3'h5, 3'h7};
    @(posedge core_clk) st.sectorValid <= 1'b0;
    repeat (20) @(posedge core_clk);
    st.bemfWindow <= 1'b0;
    rd(8'h05, {8'h2A, sup});
    rd(8'h06, {cmd, duty});
    rd(8'h04, 16'h05A3);
    rd(8'h07, 16'h02C7);
    rd(8'h03, 16'h0015);
    @(posedge core_clk) st.zeroCrossU <= 1'b1;
    @(posedge core_clk) st.zeroCrossU <= 1'b0;
    repeat (5124) @(posedge core_clk);
    st.zeroCrossU <= 1'b1;
    @(posedge core_clk) st.zeroCrossU <= 1'b0;
    repeat (30) @(posedge core_clk);
    rd(8'h02, 16'd20);
    rd(8'h01, 16'd50000);
    @(posedge core_clk) st.faultSet <= 16'h8041;
    @(posedge core_clk) st.faultSet <= 16'h0000;
    rd(8'h00, 16'h8001);
    wr(8'h00, 16'h00FE);
    rd(8'h00, 16'h8001);
    wr(8'h00, 16'h00FF);
    rd(8'h00, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(8'h90, 16'hC000 | 16'(sels[i] << 8));
      tach_count("tach toggles", 12, togs[i]);
    end
    @(posedge core_clk) st.locked <= 1'b1;
    steps(3);
    check("locked tach", {15'h0, tachOut}, 16'h0001);
    @(posedge core_clk) {st.locked, st.openLoop} <= 2'b01;
    wr(8'h90, 16'hE000);
    tach_count("first start", 12, 2);
    @(posedge core_clk) st.openLoop <= 1'b0;
    repeat (6) @(posedge core_clk) st.openLoop <= 1'b1;
    tach_count("restart", 6, 0);
    check("restart level", {15'h0, tachOut}, 16'h0001);
    wr(8'h90, 16'hD000);
    tach_count("held", 6, 0);
    check("held level", {15'h0, tachOut}, 16'h0001);
    wr(8'h90, 16'hF000);
    tach_count("policy three", 12, 2);
    wr(8'h90, 16'hC000);
    tach_count("policy zero", 12, 2);
    check("refused bytes", {8'h00, nacks}, 16'h0004);
    tally_and_finish();
  end
endmodule
`default_nettype wire
